// >>> core/ssp_cfg_bank.sv
// subaddressed configuration bank of a buffered synchronous serial port
// Summary of operation
// - index register selects the embedded register
// - data port write lands in selected register
// - data port read returns selected register
// - port 0 index at 0x038, data 0x039
// - rx control: status, enable, clock-stop, a-bis, interrupt
// - tx control: status, enable, generator resets
// - rx word 8..32 bits, 1..128 words
// - tx word 8..32 bits, 1..128 words
// - second control: data delay, companding, bit order
// - 1-bit delay: msb after frame pulse
// - bit clock is input over divider plus one
// - three-stage divider makes clock and frame
// - frame width and frame source selectable
// - generator input: cpu clock or external pin
// - pin direction, polarity, gpio when disabled
// - pin setup 0x0A00: tx pins driven, tx clock from generator
// - dma autoinc port bumps dma index
// - autoinc writes fill source, dest, count
// - dma fixed port leaves index alone
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_cfg_bank #(
    parameter int DMA_WORDS = 64
) (
    // clock, reset, enable
    input  wire logic                    clk_sys,
    input  wire logic                    rstn,
    input  wire logic                    ce,
    // memory bus
    input  wire logic [7:0]              mem_addr,
    input  wire logic                    mem_wr,
    input  wire logic                    mem_rd,
    input  wire ssp_pkg::ssp_word_t      mem_wdata,
    output ssp_pkg::ssp_word_t           mem_rdata,
    output logic                         mem_rack,
    // serial engine side
    input  wire logic [1:0][1:0]         rx_status,
    input  wire logic [1:0][1:0]         tx_status,
    input  wire logic [1:0]              tx_copy,
    input  wire ssp_pkg::ssp_word_t      port1_rx_word,
    output ssp_pkg::ssp_word_t           port1_tx_word,
    output wire ssp_pkg::ssp_banks_t     port_bank,
    output wire logic [1:0]              gen_bit_clock,
    output wire logic [1:0]              gen_frame_pulse,
    // serial pins: rx clock, tx clock, rx frame, tx frame
    input  wire logic [1:0]              ext_clock_pin,
    input  wire logic [1:0][3:0]         pin_i,
    output logic [1:0][3:0]              pin_o,
    output logic [1:0][3:0]              pin_oe_n,
    // dma channel 0 setup
    output wire ssp_pkg::ssp_word_t      chan0_source,
    output wire ssp_pkg::ssp_word_t      chan0_dest,
    output wire ssp_pkg::ssp_word_t      chan0_count
);
    localparam int DW = $clog2(DMA_WORDS);

    logic [1:0][15:0]    port_index;
    wire  [1:0][15:0]    port_rd;
    wire  [1:0][3:0]     func_val;
    wire  [1:0][3:0]     io_mode;
    ssp_pkg::ssp_word_t  dma_index;
    ssp_pkg::ssp_word_t  dma_mem [DMA_WORDS];
    ssp_pkg::ssp_word_t  next_rdata;
    logic                dma_wr;
    logic                dma_hit;

    assign dma_wr  = ce && mem_wr
                     && (mem_addr == `SSP_ADDR_DMA_AUTOINC || mem_addr == `SSP_ADDR_DMA_FIXED);
    assign dma_hit = dma_index < 16'(DMA_WORDS);

    // index registers change only on a direct write
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            port_index <= 32'h0000_0000;
        else if (ce && mem_wr && mem_addr == `SSP_ADDR_P0_INDEX)
            port_index[0] <= mem_wdata;
        else if (ce && mem_wr && mem_addr == `SSP_ADDR_P1_INDEX)
            port_index[1] <= mem_wdata;
    end

    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : g_port
            localparam logic [7:0] DATA_A = (p == 0) ? `SSP_ADDR_P0_DATA : `SSP_ADDR_P1_DATA;
            wire ssp_pkg::ssp_bank_t bank = port_bank[p];
            wire rx_on = bank[`SSP_SUB_RX_CTL][`SSP_CTL_ENABLE];
            wire tx_on = bank[`SSP_SUB_TX_CTL][`SSP_CTL_ENABLE];
            wire rx_io = bank[`SSP_SUB_PIN][`SSP_PIN_RX_IO] && !rx_on;
            wire tx_io = bank[`SSP_SUB_PIN][`SSP_PIN_TX_IO] && !tx_on;
            wire tx_frm = bank[`SSP_SUB_GEN_SRC][`SSP_SRC_FRAME_MODE] ? gen_frame_pulse[p]
                                                                      : tx_copy[p];

            ssp_port_regs u_regs (
                .clk_sys   (clk_sys),
                .rstn      (rstn),
                .ce        (ce),
                .wr_en     (mem_wr && mem_addr == DATA_A),
                .sub_addr  (port_index[p]),
                .wdata     (mem_wdata),
                .rdata     (port_rd[p]),
                .rx_status (rx_status[p]),
                .tx_status (tx_status[p]),
                .pin_level (pin_i[p]),
                .bank      (port_bank[p])
            );

            ssp_rate_gen u_gen (
                .clk_sys         (clk_sys),
                .rstn            (rstn),
                .ce              (ce),
                .gen_run         (bank[`SSP_SUB_TX_CTL][`SSP_TX_GEN_RUN]),
                .frame_run       (bank[`SSP_SUB_TX_CTL][`SSP_TX_FRAME_RUN]),
                .cpu_src         (bank[`SSP_SUB_GEN_SRC][`SSP_SRC_CPU_CLK]),
                .ext_clock_pin   (ext_clock_pin[p]),
                .divide_field    (bank[`SSP_SUB_GEN_DIV][7:0]),
                .frame_width     (bank[`SSP_SUB_GEN_DIV][15:8]),
                .frame_period    (bank[`SSP_SUB_GEN_SRC][11:0]),
                .gen_bit_clock   (gen_bit_clock[p]),
                .gen_frame_pulse (gen_frame_pulse[p]),
                .bit_edge        ()
            );

            // generator bit clock feeds both clock pins; frame pulse feeds rx frame pin, and tx frame pin only in frame mode
            assign func_val[p] = {tx_frm, gen_frame_pulse[p], gen_bit_clock[p],
                                  gen_bit_clock[p]};
            // gpio only while a section is off, so a live link cannot be hijacked
            assign io_mode[p]  = {tx_io, rx_io, tx_io, rx_io};
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            pin_o    <= 8'h00;
            pin_oe_n <= {`SSP_RESET_PIN_OE_N, `SSP_RESET_PIN_OE_N};
        end
        else if (ce)
        begin
            for (int i = 0; i < 2; i++)
            begin
                pin_oe_n[i] <= ~port_bank[i][`SSP_SUB_PIN][11:8];
                pin_o[i]    <= (io_mode[i] & port_bank[i][`SSP_SUB_PIN][7:4])
                               | (~io_mode[i] & (func_val[i]
                                  ^ port_bank[i][`SSP_SUB_PIN][3:0]));
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            port1_tx_word <= `SSP_RESET_WORD;
        else if (ce && mem_wr && mem_addr == `SSP_ADDR_P1_TX_WORD)
            port1_tx_word <= mem_wdata;
    end

    // dma index: direct write beats auto-increment
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            dma_index <= `SSP_RESET_WORD;
        else if (ce && mem_wr && mem_addr == `SSP_ADDR_DMA_INDEX)
            dma_index <= mem_wdata;
        else if (ce && (mem_wr || mem_rd) && mem_addr == `SSP_ADDR_DMA_AUTOINC)
            dma_index <= dma_index + 16'h0001;
    end

    genvar e;
    generate
        for (e = 0; e < DMA_WORDS; e++)
        begin : g_dma
            always_ff @(posedge clk_sys)
            begin
                if (!rstn)
                    dma_mem[e] <= `SSP_RESET_WORD;
                else if (dma_wr && dma_index == 16'(e))
                    dma_mem[e] <= mem_wdata;
            end
        end
    endgenerate

    assign chan0_source = dma_mem[0];
    assign chan0_dest   = dma_mem[1];
    assign chan0_count  = dma_mem[2];

    always_comb
    begin
        next_rdata = 16'h0000;
        case (mem_addr)
            `SSP_ADDR_P0_INDEX:    next_rdata = port_index[0];
            `SSP_ADDR_P0_DATA:     next_rdata = port_rd[0];
            `SSP_ADDR_P1_INDEX:    next_rdata = port_index[1];
            `SSP_ADDR_P1_DATA:     next_rdata = port_rd[1];
            `SSP_ADDR_P1_RX_WORD:  next_rdata = port1_rx_word;
            `SSP_ADDR_P1_TX_WORD:  next_rdata = port1_tx_word;
            `SSP_ADDR_DMA_INDEX:   next_rdata = dma_index;
            `SSP_ADDR_DMA_AUTOINC,
            `SSP_ADDR_DMA_FIXED:   next_rdata = dma_hit ? dma_mem[dma_index[DW-1:0]] : 16'h0000;
            default:               next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            mem_rdata <= `SSP_RESET_WORD;
            mem_rack  <= 1'b0;
        end
        else if (ce)
        begin
            mem_rack <= mem_rd;
            if (mem_rd)
                mem_rdata <= next_rdata;
        end
    end

    index_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && mem_wr && mem_addr == `SSP_ADDR_P0_INDEX
        |=> port_index[0] == $past(mem_wdata))
        else $error("index register did not take the written value");

    window_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && mem_wr && mem_addr == `SSP_ADDR_P0_DATA && port_index[0] == 16'h0002
        |=> port_bank[0][2] == $past(mem_wdata))
        else $error("window write missed the selected register");

    window_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && mem_rd && !mem_wr && mem_addr == `SSP_ADDR_P1_DATA && port_index[1] == 16'h0006
        |=> mem_rack && mem_rdata == port_bank[1][6])
        else $error("window read returned the wrong register");

    undef_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && mem_rd && mem_addr == `SSP_ADDR_P0_DATA && port_index[0] == 16'h0008
        |=> mem_rack && mem_rdata == 16'h0000)
        else $error("undefined sub-address did not read zero");

    index_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(ce && mem_wr && mem_addr == `SSP_ADDR_P0_INDEX) |=> $stable(port_index[0]))
        else $error("index register changed without a write");

    dma_autoinc_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && (mem_rd || mem_wr) && mem_addr == `SSP_ADDR_DMA_AUTOINC
        |=> dma_index == $past(dma_index) + 16'h0001)
        else $error("dma index did not advance");

    dma_fixed_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && (mem_rd || mem_wr) && mem_addr == `SSP_ADDR_DMA_FIXED |=> $stable(dma_index))
        else $error("fixed dma port moved the index");

    chan_order_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && mem_wr && mem_addr == `SSP_ADDR_DMA_AUTOINC && dma_index == 16'h0002
        |=> chan0_count == $past(mem_wdata) && dma_index == 16'h0003)
        else $error("autoinc writes landed out of order");

    tx_clock_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && port_bank[1][`SSP_SUB_PIN] == 16'h0A00 && port_bank[1][`SSP_SUB_TX_CTL][0]
        |=> !pin_oe_n[1][1] && pin_o[1][1] == $past(gen_bit_clock[1]) && pin_oe_n[1][0])
        else $error("tx bit clock pin not driven by the generator");

    read_ack_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && mem_rd |=> mem_rack)
        else $error("read was not acknowledged");

    fixed_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && mem_wr && mem_addr == `SSP_ADDR_DMA_FIXED && dma_index == 16'h0000
        |=> chan0_source == $past(mem_wdata))
        else $error("fixed dma port missed the indexed word");

    gpio_out_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && port_bank[0][`SSP_SUB_PIN][`SSP_PIN_RX_IO] && !port_bank[0][0][0]
        |=> pin_o[0][0] == $past(port_bank[0][`SSP_SUB_PIN][4]))
        else $error("gpio value not on the rx clock pin");
endmodule : ssp_cfg_bank

// >>> core/ssp_map.svh
// register map, field positions and reset values of the serial port bank
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// memory bus word addresses
`define SSP_ADDR_P0_INDEX     8'h38
`define SSP_ADDR_P0_DATA      8'h39
`define SSP_ADDR_P1_RX_WORD   8'h41
`define SSP_ADDR_P1_TX_WORD   8'h43
`define SSP_ADDR_P1_INDEX     8'h48
`define SSP_ADDR_P1_DATA      8'h49
`define SSP_ADDR_DMA_INDEX    8'h54
`define SSP_ADDR_DMA_AUTOINC  8'h55
`define SSP_ADDR_DMA_FIXED    8'h56

// sub-addresses behind the window data port
`define SSP_SUB_RX_CTL        4'h0
`define SSP_SUB_TX_CTL        4'h1
`define SSP_SUB_RX_FRM1       4'h2
`define SSP_SUB_RX_FRM2       4'h3
`define SSP_SUB_TX_FRM1       4'h4
`define SSP_SUB_TX_FRM2       4'h5
`define SSP_SUB_GEN_DIV       4'h6
`define SSP_SUB_GEN_SRC       4'h7
`define SSP_SUB_PIN           4'hE

// field positions
`define SSP_CTL_ENABLE        0
`define SSP_CTL_STATUS_LSB    1
`define SSP_CTL_STATUS_MASK   16'h0006
`define SSP_RX_INT_MODE_LSB   4
`define SSP_RX_A_BIS          6
`define SSP_RX_CLKSTOP_LSB    11
`define SSP_TX_GEN_RUN        6
`define SSP_TX_FRAME_RUN      7
`define SSP_FRM1_WORD_LSB     5
`define SSP_FRM1_WORDS_LSB    8
`define SSP_FRM2_DELAY_LSB    0
`define SSP_FRM2_COMPAND_LSB  3
`define SSP_SRC_FRAME_MODE    12
`define SSP_SRC_CPU_CLK       13
`define SSP_PIN_RX_IO         12
`define SSP_PIN_TX_IO         13

// reset values
`define SSP_RESET_WORD        16'h0000
`define SSP_RESET_PIN_OE_N    4'hF

`endif

// >>> core/ssp_pkg.sv
// shared types of the serial port configuration bank
package ssp_pkg;
    typedef logic [15:0]            ssp_word_t;
    typedef logic [15:0][15:0]      ssp_bank_t;
    typedef logic [1:0][15:0][15:0] ssp_banks_t;
    typedef logic [3:0]             ssp_pins_t;
endpackage : ssp_pkg

// >>> core/ssp_port_regs.sv
// embedded registers of one serial port, reached through the window data port
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_port_regs (
    // clock, reset, enable
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    input  wire logic               ce,
    // window access
    input  wire logic               wr_en,
    input  wire ssp_pkg::ssp_word_t sub_addr,
    input  wire ssp_pkg::ssp_word_t wdata,
    output ssp_pkg::ssp_word_t      rdata,
    // live state from the port
    input  wire logic [1:0]         rx_status,
    input  wire logic [1:0]         tx_status,
    input  wire ssp_pkg::ssp_pins_t pin_level,
    // embedded registers
    output ssp_pkg::ssp_bank_t      bank
);
    logic slot_ok;

    // only sub-addresses 0..7 and 14 exist
    assign slot_ok = (sub_addr[15:3] == 13'h0000) || (sub_addr == {12'h000, `SSP_SUB_PIN});

    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_slot
            localparam bit        LIVE    = (g < 8) || (g == 14);
            localparam logic [15:0] RO_MASK = (g < 2) ? `SSP_CTL_STATUS_MASK : 16'h0000;
            always_ff @(posedge clk_sys)
            begin
                if (!rstn)
                    bank[g] <= `SSP_RESET_WORD;
                else if (LIVE && ce && wr_en && sub_addr == 16'(g))
                    bank[g] <= wdata & ~RO_MASK;
            end
        end
    endgenerate

    always_comb
    begin
        rdata = 16'h0000;
        if (slot_ok)
            rdata = bank[sub_addr[3:0]];
        if (sub_addr == {12'h000, `SSP_SUB_RX_CTL})
            rdata[`SSP_CTL_STATUS_LSB +: 2] = rx_status;
        if (sub_addr == {12'h000, `SSP_SUB_TX_CTL})
            rdata[`SSP_CTL_STATUS_LSB +: 2] = tx_status;
        // gpio readback shows the wire, not the written value
        if (sub_addr == {12'h000, `SSP_SUB_PIN})
            rdata[7:4] = pin_level;
    end
endmodule : ssp_port_regs

// >>> core/ssp_rate_gen.sv
// three-stage sample-rate generator: source select, bit clock divider, frame pulse
`timescale 1ns/1ps
module ssp_rate_gen (
    // clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        ce,
    // control
    input  wire logic        gen_run,
    input  wire logic        frame_run,
    input  wire logic        cpu_src,
    input  wire logic        ext_clock_pin,
    input  wire logic [7:0]  divide_field,
    input  wire logic [7:0]  frame_width,
    input  wire logic [11:0] frame_period,
    // generated signals
    output logic             gen_bit_clock,
    output logic             gen_frame_pulse,
    output logic             bit_edge
);
    logic        ext_d;
    logic        src_tick;
    logic [7:0]  div_cnt;
    logic [11:0] per_cnt;

    // ext pin is synchronous already, so a plain edge detect suffices
    assign src_tick = cpu_src ? 1'b1 : (ext_clock_pin & ~ext_d);

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            ext_d <= 1'b0;
        else if (ce)
            ext_d <= ext_clock_pin;
    end

    // a divide-by-one leaves the clock high: cannot toggle faster than clk_sys
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || !gen_run)
        begin
            div_cnt       <= 8'h00;
            gen_bit_clock <= 1'b0;
            bit_edge      <= 1'b0;
        end
        else if (ce)
        begin
            bit_edge <= 1'b0;
            if (src_tick && div_cnt >= divide_field)
            begin
                div_cnt       <= 8'h00;
                gen_bit_clock <= 1'b1;
                bit_edge      <= 1'b1;
            end
            else if (src_tick)
            begin
                div_cnt <= div_cnt + 8'h01;
                if (div_cnt == (divide_field >> 1))
                    gen_bit_clock <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn || !frame_run)
        begin
            per_cnt         <= 12'h000;
            gen_frame_pulse <= 1'b0;
        end
        else if (ce && bit_edge)
        begin
            per_cnt         <= (per_cnt >= frame_period) ? 12'h000 : per_cnt + 12'h001;
            gen_frame_pulse <= ({4'h0, frame_width} >= per_cnt);
        end
    end

    gen_divide_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (ce && gen_run && bit_edge && cpu_src && divide_field == 8'h09)
        ##1 (ce && gen_run && cpu_src && divide_field == 8'h09)[*8]
        ##1 (ce && gen_run && cpu_src && divide_field == 8'h09)
        |=> bit_edge)
        else $error("bit clock period is not divide field plus one");

    gen_stop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !gen_run |=> !gen_bit_clock && !bit_edge)
        else $error("bit clock runs while generator held in reset");
endmodule : ssp_rate_gen

// >>> verification/ssp_bus_master.sv
// bus master model: word accesses and window accesses on the memory bus
`timescale 1ns/1ps
module ssp_bus_master (
    // clock
    input  wire logic               clk_sys,
    // memory bus
    output logic [7:0]              mem_addr,
    output logic                    mem_wr,
    output logic                    mem_rd,
    output ssp_pkg::ssp_word_t      mem_wdata,
    input  wire ssp_pkg::ssp_word_t mem_rdata,
    input  wire logic               mem_rack
);
    initial
    begin
        mem_addr  = 8'h00;
        mem_wr    = 1'b0;
        mem_rd    = 1'b0;
        mem_wdata = 16'h0000;
    end
    // one-cycle strobe, then an idle edge so a strobe is never set twice in a step
    task automatic wr(input logic [7:0] a, input ssp_pkg::ssp_word_t d);
        @(posedge clk_sys);
        #10;
        mem_addr  = a;
        mem_wdata = d;
        mem_wr    = 1'b1;
        @(posedge clk_sys);
        #10;
        mem_wr    = 1'b0;
    endtask : wr
    // data only counts with the ack; unknown otherwise forces a mismatch
    task automatic rd(input logic [7:0] a, output ssp_pkg::ssp_word_t d);
        @(posedge clk_sys);
        #10;
        mem_addr = a;
        mem_rd   = 1'b1;
        @(posedge clk_sys);
        #10;
        mem_rd   = 1'b0;
        d        = (mem_rack === 1'b1) ? mem_rdata : 16'hXXXX;
    endtask : rd
    // index register first, shared data port next
    task automatic win_wr(input logic [7:0] ia, input ssp_pkg::ssp_word_t s,
                          input ssp_pkg::ssp_word_t d);
        wr(ia, s);
        wr(ia + 8'h01, d);
    endtask : win_wr
endmodule : ssp_bus_master

// >>> verification/ssp_cfg_bank_test.sv
// self-checking bench of the serial port configuration bank
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_cfg_bank_test;
    localparam ssp_pkg::ssp_word_t SUB [9] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003,
        16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h000E};
    // enables held at 0 while configuring
    localparam ssp_pkg::ssp_word_t VAL [9] = '{16'h0000, 16'h02C0, 16'h0040, 16'h0001,
        16'h0040, 16'h0001, 16'h0009, 16'h2000, 16'h0A00};
    logic                clk_sys   = 1'b0;
    logic                rstn      = 1'b0;
    logic                ce        = 1'b1;
    logic [7:0]          mem_addr;
    logic                mem_wr;
    logic                mem_rd;
    ssp_pkg::ssp_word_t  mem_wdata;
    ssp_pkg::ssp_word_t  mem_rdata;
    logic                mem_rack;
    logic [1:0][1:0]     rx_status = {2'b01, 2'b10};
    logic [1:0][1:0]     tx_status = {2'b01, 2'b11};
    logic [1:0]          tx_copy   = 2'b00;
    logic [1:0]          ext_clk   = 2'b00;
    ssp_pkg::ssp_word_t  rx_word   = 16'h5A5A;
    ssp_pkg::ssp_word_t  tx_word;
    ssp_pkg::ssp_banks_t port_bank;
    logic [1:0]          gclk;
    logic [1:0]          gfrm;
    logic [1:0][3:0]     pin_i     = {4'h0, 4'hA};
    logic [1:0][3:0]     pin_o;
    logic [1:0][3:0]     pin_oe_n;
    ssp_pkg::ssp_word_t  c_src;
    ssp_pkg::ssp_word_t  c_dst;
    ssp_pkg::ssp_word_t  c_cnt;
    logic [63:0]         hist;
    logic [63:0]         ghist;
    int                  r1;
    int                  r2;
    int                  hi;
    int                  n_fail    = 0;
    int                  tests_run = 0;

    always #50 clk_sys = ~clk_sys;

    ssp_cfg_bank #(.DMA_WORDS(64)) ssp_cfg_bank_i (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .mem_addr(mem_addr), .mem_wr(mem_wr),
        .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rack(mem_rack),
        .rx_status(rx_status), .tx_status(tx_status), .tx_copy(tx_copy),
        .port1_rx_word(rx_word), .port1_tx_word(tx_word), .port_bank(port_bank),
        .gen_bit_clock(gclk), .gen_frame_pulse(gfrm), .ext_clock_pin(ext_clk),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .chan0_source(c_src), .chan0_dest(c_dst), .chan0_count(c_cnt));

    ssp_bus_master ssp_bus_master_i (
        .clk_sys(clk_sys), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rack(mem_rack));

    task automatic chk(input string nm, input ssp_pkg::ssp_word_t e,
                       input ssp_pkg::ssp_word_t g);
        tests_run++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    task automatic rchk(input string nm, input logic [7:0] a, input ssp_pkg::ssp_word_t e);
        ssp_pkg::ssp_word_t g;
        ssp_bus_master_i.rd(a, g);
        chk(nm, e, g);
    endtask : rchk

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    // a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        final_report();
    end

    initial
    begin
        repeat (6) @(posedge clk_sys);
        #10;
        rstn = 1'b1;
        rchk("p0 index", `SSP_ADDR_P0_INDEX, 16'h0000);
        rchk("p0 rx ctl", `SSP_ADDR_P0_DATA, 16'h0004);
        for (int i = 0; i < 9; i++)
            ssp_bus_master_i.win_wr(`SSP_ADDR_P1_INDEX, SUB[i], VAL[i]);
        for (int i = 0; i < 9; i++)
        begin
            ssp_bus_master_i.wr(`SSP_ADDR_P1_INDEX, SUB[i]);
            rchk("p1 sub", `SSP_ADDR_P1_DATA, VAL[i] | (i < 2 ? 16'h0002 : 16'h0000));
        end
        rchk("p1 index", `SSP_ADDR_P1_INDEX, 16'h000E);
        rchk("p1 pin again", `SSP_ADDR_P1_DATA, 16'h0A00);
        ssp_bus_master_i.win_wr(`SSP_ADDR_P1_INDEX, 16'h0000, 16'h0001);
        ssp_bus_master_i.win_wr(`SSP_ADDR_P1_INDEX, 16'h0001, 16'h02C1);
        rchk("p1 tx ctl", `SSP_ADDR_P1_DATA, 16'h02C3);
        chk("p1 oe_n", 16'h0005, {12'h000, pin_oe_n[1]});
        // tx clock pin from the generator, cpu clock source
        for (int i = 0; i < 64; i++)
        begin
            @(posedge clk_sys);
            #10;
            hist[i] = pin_o[1][1];
            ghist[i] = gclk[1];
        end
        r1 = -1;
        r2 = -1;
        hi = 0;
        for (int i = 1; i < 64; i++)
            if (hist[i] === 1'b1 && hist[i-1] === 1'b0)
            begin
                if (r1 < 0)
                    r1 = i;
                else if (r2 < 0)
                    r2 = i;
            end
        for (int i = 0; i < 64; i++)
            if (i >= r1 && i < r2 && hist[i] === 1'b1)
                hi++;
        chk("bit clock period", 16'h000A, 16'(r2 - r1));
        chk("bit clock high", 16'h0005, 16'(hi));
        chk("pin follows gen", ghist[62:47], hist[63:48]);
        chk("gen frame", 16'h0001, {15'h0000, gfrm[1]});
        // frame mode bit clear: tx frame pin follows the copy indication
        tx_copy = 2'b10;
        repeat (3) @(posedge clk_sys);
        #10;
        chk("tx frame on copy", 16'h0001, {15'h0000, pin_o[1][3]});
        tx_copy = 2'b00;
        repeat (3) @(posedge clk_sys);
        #10;
        chk("tx frame off", 16'h0000, {15'h0000, pin_o[1][3]});
        ssp_bus_master_i.win_wr(`SSP_ADDR_P0_INDEX, 16'h0002, 16'h1234);
        chk("p0 bank 2", 16'h1234, port_bank[0][2]);
        chk("p1 bank 2", 16'h0040, port_bank[1][2]);
        ssp_bus_master_i.win_wr(`SSP_ADDR_P0_INDEX, 16'h0008, 16'hBEEF);
        rchk("undef sub", `SSP_ADDR_P0_DATA, 16'h0000);
        chk("undef bank", 16'h0000, port_bank[0][8]);
        rchk("unmapped", 8'h20, 16'h0000);
        // status bits are live, a write cannot set them
        ssp_bus_master_i.win_wr(`SSP_ADDR_P0_INDEX, 16'h0000, 16'h0006);
        rchk("p0 status ro", `SSP_ADDR_P0_DATA, 16'h0004);
        // receiver off: rx clock pin as output, driven from the gpio field
        ssp_bus_master_i.win_wr(`SSP_ADDR_P0_INDEX, 16'h000E, 16'h1150);
        repeat (2) @(posedge clk_sys);
        #10;
        chk("p0 oe_n", 16'h000E, {12'h000, pin_oe_n[0]});
        chk("p0 gpio out", 16'h0001, {15'h0000, pin_o[0][0]});
        rchk("p0 gpio in", `SSP_ADDR_P0_DATA, 16'h11A0);
        ce = 1'b0;
        ssp_bus_master_i.wr(`SSP_ADDR_P0_INDEX, 16'h0005);
        ce = 1'b1;
        rchk("index frozen", `SSP_ADDR_P0_INDEX, 16'h000E);
        rchk("rx word", `SSP_ADDR_P1_RX_WORD, 16'h5A5A);
        ssp_bus_master_i.wr(`SSP_ADDR_P1_TX_WORD, 16'hC3C3);
        chk("tx word out", 16'hC3C3, tx_word);
        ssp_bus_master_i.wr(`SSP_ADDR_DMA_INDEX, 16'h0000);
        ssp_bus_master_i.wr(`SSP_ADDR_DMA_AUTOINC, 16'h0041);
        ssp_bus_master_i.wr(`SSP_ADDR_DMA_AUTOINC, 16'h1000);
        ssp_bus_master_i.wr(`SSP_ADDR_DMA_AUTOINC, 16'h00FF);
        chk("chan0 source", 16'h0041, c_src);
        chk("chan0 dest", 16'h1000, c_dst);
        chk("chan0 count", 16'h00FF, c_cnt);
        rchk("dma index 3", `SSP_ADDR_DMA_INDEX, 16'h0003);
        ssp_bus_master_i.wr(`SSP_ADDR_DMA_INDEX, 16'h0001);
        rchk("autoinc read", `SSP_ADDR_DMA_AUTOINC, 16'h1000);
        rchk("dma index 2", `SSP_ADDR_DMA_INDEX, 16'h0002);
        ssp_bus_master_i.wr(`SSP_ADDR_DMA_INDEX, 16'h0000);
        ssp_bus_master_i.wr(`SSP_ADDR_DMA_FIXED, 16'h7777);
        ssp_bus_master_i.wr(`SSP_ADDR_DMA_FIXED, 16'h8888);
        rchk("dma index 0", `SSP_ADDR_DMA_INDEX, 16'h0000);
        chk("fixed source", 16'h8888, c_src);
        chk("fixed dest", 16'h1000, c_dst);
        // external pin feeds the generator: two rising pin edges per bit clock period
        ssp_bus_master_i.win_wr(`SSP_ADDR_P0_INDEX, 16'h0006, 16'h0001);
        ssp_bus_master_i.win_wr(`SSP_ADDR_P0_INDEX, 16'h0001, 16'h0040);
        for (int i = 0; i < 3; i++)
        begin
            ext_clk[0] = 1'b1;
            repeat (2) @(posedge clk_sys);
            #10;
            ext_clk[0] = 1'b0;
            repeat (2) @(posedge clk_sys);
            #10;
            if (i > 0)
                chk("ext clock", {15'h0000, i[0]}, {15'h0000, gclk[0]});
        end
        final_report();
    end
endmodule : ssp_cfg_bank_test
